// ### inc/wfd_pkg.sv
/*
 * Shared constants, carrier types and the CRC-16 step for the wake frame
 * detector. Assumes byte-wide receive data on the MAC receive clock.
 */
`default_nettype none

package wfd_pkg;

	////////////////////////////////////////////////////////////////////////
	// Sizes and positions
	localparam int NUM_FILTERS    = 4;
	localparam int CMD_ENABLE_POS = 0;
	localparam int CMD_MCAST_POS  = 3;
	localparam int STS_FRAME_POS  = 0;
	localparam int STS_REMOTE_POS = 1;
	localparam int ADDR_BYTES     = 6;

	localparam logic [8:0] MASK_SPAN = 9'h01F;
	localparam logic [8:0] IDX_ZERO  = 9'h000;
	localparam logic [8:0] IDX_ONE   = 9'h001;
	localparam logic [8:0] IDX_MAX   = 9'h1FF;
	localparam logic [8:0] HDR_LAST  = 9'h00B;
	localparam logic [8:0] DA_BYTES  = 9'h006;

	////////////////////////////////////////////////////////////////////////
	// Remote-wake pattern figures
	localparam logic [7:0] SYNC_BYTE = 8'hFF;
	localparam logic [2:0] SYNC_ZERO = 3'h0;
	localparam logic [2:0] SYNC_ONE  = 3'h1;
	localparam logic [2:0] SYNC_FULL = 3'h6;
	localparam logic [2:0] POS_ZERO  = 3'h0;
	localparam logic [2:0] POS_ONE   = 3'h1;
	localparam logic [2:0] POS_LAST  = 3'h5;
	localparam logic [3:0] REP_ZERO  = 4'h0;
	localparam logic [3:0] REP_ONE   = 4'h1;
	localparam logic [3:0] REP_LAST  = 4'hF;

	////////////////////////////////////////////////////////////////////////
	// CRC-16, bit-serial, least significant data bit first
	localparam logic [15:0] CRC_INIT = 16'hFFFF;
	localparam logic [15:0] CRC_POLY = 16'h8005;

	////////////////////////////////////////////////////////////////////////
	// Carriers
	typedef struct packed {
		logic [31:0] mask;
		logic [3:0]  command;
		logic [7:0]  offset;
		logic [15:0] crc;
	} wfd_filter_cfg_t;

	typedef struct packed {
		logic       valid;
		logic       sof;
		logic       eof;
		logic [7:0] data;
	} wfd_rx_byte_t;

	typedef enum {
		WFD_MP_HEADER,
		WFD_MP_SYNC,
		WFD_MP_ADDR,
		WFD_MP_DONE
	} wfd_mp_state_t;

	function automatic logic [15:0] wfd_crc16_byte(input logic [15:0] crc_in,
		input logic [7:0] data);
		logic [15:0] c;
		c = crc_in;
		for (int b = 0; b < 8; b++)
		begin
			if (c[15] ^ data[b])
				c = {c[14:0], 1'b0} ^ CRC_POLY;
			else
				c = {c[14:0], 1'b0};
		end
		return c;
	endfunction

endpackage

`default_nettype wire

// ### core/wfd_crc_filter.sv
/*
 * One pattern filter: incremental masked CRC-16 over a frame and the
 * end-of-frame comparison. Assumes the top qualifies the destination.
 */
`timescale 1ns/1ps
`default_nettype none

module wfd_crc_filter (
	input  wire logic                     ref_clk,        // Receive clock
	input  wire logic                     reset_n,        // Async reset, low
	input  wire wfd_pkg::wfd_filter_cfg_t cfg,            // Filter settings
	input  wire wfd_pkg::wfd_rx_byte_t    rx,             // Receive byte
	input  wire logic                     frame_multicast, // Group address
	input  wire logic                     frame_addr_ok,  // Destination taken
	output logic                          hit             // Match pulse
);

	logic [8:0]  idx_r;
	logic [15:0] crc_r;
	logic        hit_r;

	////////////////////////////////////////////////////////////////////////
	// Byte window
	wire [8:0]  byte_idx = rx.sof ? wfd_pkg::IDX_ZERO : idx_r;
	wire [8:0]  rel      = byte_idx - {1'b0, cfg.offset};
	wire        after    = byte_idx >= {1'b0, cfg.offset};
	wire        in_win   = after && (rel < wfd_pkg::MASK_SPAN) && cfg.mask[rel[4:0]];
	wire [15:0] crc_base = rx.sof ? wfd_pkg::CRC_INIT : crc_r;
	wire [15:0] crc_nxt  = in_win ? wfd_pkg::wfd_crc16_byte(crc_base, rx.data) : crc_base;
	wire        enabled  = cfg.command[wfd_pkg::CMD_ENABLE_POS];
	wire        type_ok  = cfg.command[wfd_pkg::CMD_MCAST_POS] == frame_multicast;
	wire        crc_eq   = crc_nxt == cfg.crc;
	wire [8:0]  idx_nxt  = (byte_idx == wfd_pkg::IDX_MAX) ? wfd_pkg::IDX_MAX : byte_idx + wfd_pkg::IDX_ONE;
	wire        hit_nxt  = rx.valid && rx.eof && enabled && type_ok && frame_addr_ok && crc_eq;

	////////////////////////////////////////////////////////////////////////
	// State
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			idx_r <= wfd_pkg::IDX_ZERO;
			crc_r <= wfd_pkg::CRC_INIT;
			hit_r <= 1'b0;
		end
		else
		begin
			if (rx.valid)
			begin
				idx_r <= idx_nxt;
				crc_r <= crc_nxt;
			end
			hit_r <= hit_nxt;
		end
	end

	assign hit = hit_r;

endmodule

`default_nettype wire

// ### core/wake_frame_detector.sv
/*
 * Wake-up detection in the MAC receive path: four pattern filters and the
 * remote-wake pattern detector, with status, interrupt and power event.
 * Assumes byte-wide receive data on ref_clk, one byte per valid cycle.
 * The host holds the filter table and station address steady while frames
 * arrive, and pulses each status clear for a single cycle.
 */
// Notes on behaviour
// - Command bit 3 picks multicast or unicast
// - Filter used only while its enable set
// - Offset picks first byte in the CRC
// - Offset zero is first destination byte
// - Stored CRC equals computed CRC means wake
// - Remote-wake mode halts normal reception
// - Detection raises interrupt or power event
// - Detection sets remote-wake-received status
// - Clearing remote-wake enable resumes normal reception; here frame-wake enable and low power must be clear too
// - Examine station or broadcast addressed frames
// - Multicast frames also accepted for remote wake
// - Search six all-ones bytes after addresses
// - Sixteen unbroken address copies declare the pattern
// - Broken copies restart the all-ones search
// - Copies anywhere, sync immediately before them
// - Full power: detection follows enable bit
// - Low power forces both detections on
// - Mask bit j (0 to 30) takes byte offset plus j; bit 31 unused
// - Four independent filters with own settings
// - Filter hit sets frame-wake-received status
`timescale 1ns/1ps
`default_nettype none

module wake_frame_detector (
	input  wire logic                     ref_clk,               // Receive clock
	input  wire logic                     reset_n,               // Async reset, low
	input  wire wfd_pkg::wfd_rx_byte_t    rx,                    // Receive byte
	input  wire logic [47:0]              station_address,       // Byte 0 in [7:0]
	input  wire wfd_pkg::wfd_filter_cfg_t filter_cfg [wfd_pkg::NUM_FILTERS], // Filter table
	input  wire logic                     remote_wake_enable,    // Control bit
	input  wire logic                     frame_wake_enable,     // Control bit
	input  wire logic                     first_low_power_state, // Low power level
	input  wire logic                     wake_irq_enable,       // Route to interrupt
	input  wire logic                     wake_pme_enable,       // Route to event
	input  wire logic [1:0]               status_clear,          // Clear pulses
	output logic                          frame_wake_received,   // Sticky status
	output logic                          remote_wake_received,  // Sticky status
	output logic                          host_irq,              // Host interrupt
	output logic                          power_event_output,    // Power event
	output logic                          normal_rx_enable       // Normal reception
);

	////////////////////////////////////////////////////////////////////////
	// Mode selection
	wire remote_active = remote_wake_enable | first_low_power_state;
	wire frame_active  = frame_wake_enable | first_low_power_state;
	// Either detection mode holds normal reception off until it is cleared
	wire normal_nxt    = !(remote_active | frame_active);

	// All-ones byte: broadcast destination and sync stream alike
	function automatic logic is_ones(input logic [7:0] b);
		return b == wfd_pkg::SYNC_BYTE;
	endfunction

	// Station address byte k, k counted in wire order
	function automatic logic [7:0] addr_byte(input logic [47:0] addr, input logic [2:0] k);
		logic [7:0] b;
		b = 8'h00;
		for (int i = 0; i < wfd_pkg::ADDR_BYTES; i++)
		begin
			if (k == 3'(i))
				b = addr[8*i +: 8];
		end
		return b;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Destination address tracking
	logic [8:0] idx_r;
	logic       da_station_r;
	logic       da_bcast_r;
	logic       da_mcast_r;

	// Destination class, settled once byte five has passed
	wire [8:0] byte_idx   = rx.sof ? wfd_pkg::IDX_ZERO : idx_r;
	wire       in_da      = byte_idx < wfd_pkg::DA_BYTES;
	wire [7:0] da_expect  = addr_byte(station_address, byte_idx[2:0]);
	wire       st_base    = rx.sof ? 1'b1 : da_station_r;
	wire       bc_base    = rx.sof ? 1'b1 : da_bcast_r;
	wire       st_nxt     = in_da ? st_base && (rx.data == da_expect) : st_base;
	wire       bc_nxt     = in_da ? bc_base && is_ones(rx.data) : bc_base;
	// Group bit rides in bit zero of the first destination byte
	wire       mc_nxt     = rx.sof ? rx.data[0] : da_mcast_r;
	wire [8:0] idx_nxt    = (byte_idx == wfd_pkg::IDX_MAX) ? wfd_pkg::IDX_MAX
		: byte_idx + wfd_pkg::IDX_ONE;
	// Broadcast carries the group bit, so it counts as multicast too
	wire       frame_ok   = da_station_r | da_bcast_r | da_mcast_r;

	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			idx_r        <= wfd_pkg::IDX_ZERO;
			da_station_r <= 1'b0;
			da_bcast_r   <= 1'b0;
			da_mcast_r   <= 1'b0;
		end
		else if (rx.valid)
		begin
			idx_r        <= idx_nxt;
			da_station_r <= st_nxt;
			da_bcast_r   <= bc_nxt;
			da_mcast_r   <= mc_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pattern filters
	logic [wfd_pkg::NUM_FILTERS-1:0] filter_hit;
	// Filters take station and group frames; broadcast is a group frame
	wire                             filter_addr_ok = da_station_r | da_mcast_r;

	// Filters run side by side on the same bytes
	generate
		for (genvar g = 0; g < wfd_pkg::NUM_FILTERS; g++)
		begin : g_filter
			wfd_crc_filter u_filter (
				.ref_clk         (ref_clk),
				.reset_n         (reset_n),
				.cfg             (filter_cfg[g]),
				.rx              (rx),
				.frame_multicast (da_mcast_r),
				.frame_addr_ok   (filter_addr_ok),
				.hit             (filter_hit[g])
			);
		end
	endgenerate

	// Hits outside frame-wake mode are dropped, not held
	wire frame_event = frame_active && (|filter_hit);

	////////////////////////////////////////////////////////////////////////
	// Remote-wake pattern search
	wfd_pkg::wfd_mp_state_t mp_state_r;
	wfd_pkg::wfd_mp_state_t mp_state_nxt;
	logic [2:0]             ff_cnt_r;
	logic [2:0]             ff_cnt_nxt;
	logic [2:0]             pos_r;
	logic [2:0]             pos_nxt;
	logic [3:0]             rep_r;
	logic [3:0]             rep_nxt;
	logic                   mp_found;

	wire       is_sync    = is_ones(rx.data);
	wire [7:0] addr_want  = addr_byte(station_address, pos_r);
	wire [7:0] addr_first = addr_byte(station_address, wfd_pkg::POS_ZERO);
	wire [2:0] ff_inc     = (ff_cnt_r == wfd_pkg::SYNC_FULL) ? wfd_pkg::SYNC_FULL
		: ff_cnt_r + wfd_pkg::SYNC_ONE;
	wire [2:0] ff_restart = is_sync ? wfd_pkg::SYNC_ONE : wfd_pkg::SYNC_ZERO;

	// Search decode
	wire       hdr_done   = byte_idx == wfd_pkg::HDR_LAST;
	wire       sync_done  = ff_cnt_r == wfd_pkg::SYNC_FULL;
	wire       copy_start = sync_done && (rx.data == addr_first);
	wire       addr_ok    = rx.data == addr_want;
	wire       copy_end   = pos_r == wfd_pkg::POS_LAST;
	wire       last_copy  = rep_r == wfd_pkg::REP_LAST;

	always_comb
	begin
		mp_state_nxt = mp_state_r;
		ff_cnt_nxt   = ff_cnt_r;
		pos_nxt      = pos_r;
		rep_nxt      = rep_r;
		mp_found     = 1'b0;
		// A frame start always restarts from the header
		if (rx.sof)
		begin
			mp_state_nxt = wfd_pkg::WFD_MP_HEADER;
			ff_cnt_nxt   = wfd_pkg::SYNC_ZERO;
		end
		else
		begin
			case (mp_state_r)
				wfd_pkg::WFD_MP_HEADER:
				begin
					if (hdr_done)
					begin
						mp_state_nxt = wfd_pkg::WFD_MP_SYNC;
						ff_cnt_nxt   = wfd_pkg::SYNC_ZERO;
					end
				end
				wfd_pkg::WFD_MP_SYNC:
				begin
					if (copy_start)
					begin
						mp_state_nxt = wfd_pkg::WFD_MP_ADDR;
						pos_nxt      = wfd_pkg::POS_ONE;
						rep_nxt      = wfd_pkg::REP_ZERO;
					end
					// Extra all-ones bytes keep the count saturated
					else if (is_sync)
						ff_cnt_nxt = ff_inc;
					else
						ff_cnt_nxt = wfd_pkg::SYNC_ZERO;
				end
				wfd_pkg::WFD_MP_ADDR:
				begin
					if (addr_ok)
					begin
						if (copy_end)
						begin
							pos_nxt = wfd_pkg::POS_ZERO;
							if (last_copy)
							begin
								mp_state_nxt = wfd_pkg::WFD_MP_DONE;
								mp_found     = frame_ok;
							end
							else
								rep_nxt = rep_r + wfd_pkg::REP_ONE;
						end
						else
							pos_nxt = pos_r + wfd_pkg::POS_ONE;
					end
					else
					begin
						// The breaking byte may itself open a new sync
						mp_state_nxt = wfd_pkg::WFD_MP_SYNC;
						ff_cnt_nxt   = ff_restart;
					end
				end
				// One detection per frame; only a new start leaves
				wfd_pkg::WFD_MP_DONE:
					mp_state_nxt = wfd_pkg::WFD_MP_DONE;
				default:
					mp_state_nxt = wfd_pkg::WFD_MP_HEADER;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			mp_state_r <= wfd_pkg::WFD_MP_HEADER;
			ff_cnt_r   <= wfd_pkg::SYNC_ZERO;
			pos_r      <= wfd_pkg::POS_ZERO;
			rep_r      <= wfd_pkg::REP_ZERO;
		end
		else if (rx.valid)
		begin
			mp_state_r <= mp_state_nxt;
			ff_cnt_r   <= ff_cnt_nxt;
			pos_r      <= pos_nxt;
			rep_r      <= rep_nxt;
		end
	end

	// Gate on valid: the decode also runs on idle cycles
	wire remote_event = rx.valid && mp_found && remote_active;

	////////////////////////////////////////////////////////////////////////
	// Status and signalling
	logic frame_rcvd_r;
	logic remote_rcvd_r;
	logic host_irq_r;
	logic pme_r;
	logic normal_rx_r;

	// A new event wins over a clear in the same cycle
	wire frame_rcvd_nxt  = frame_event
		| (frame_rcvd_r & ~status_clear[wfd_pkg::STS_FRAME_POS]);
	wire remote_rcvd_nxt = remote_event
		| (remote_rcvd_r & ~status_clear[wfd_pkg::STS_REMOTE_POS]);
	wire any_rcvd_nxt    = frame_rcvd_nxt | remote_rcvd_nxt;
	// Routing follows the next status so both outputs rise together
	wire irq_nxt         = any_rcvd_nxt & wake_irq_enable;
	wire pme_nxt         = any_rcvd_nxt & wake_pme_enable;

	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			frame_rcvd_r  <= 1'b0;
			remote_rcvd_r <= 1'b0;
			host_irq_r    <= 1'b0;
			pme_r         <= 1'b0;
			normal_rx_r   <= 1'b1;
		end
		else
		begin
			frame_rcvd_r  <= frame_rcvd_nxt;
			remote_rcvd_r <= remote_rcvd_nxt;
			host_irq_r    <= irq_nxt;
			pme_r         <= pme_nxt;
			normal_rx_r   <= normal_nxt;
		end
	end

	assign frame_wake_received  = frame_rcvd_r;
	assign remote_wake_received = remote_rcvd_r;
	assign host_irq             = host_irq_r;
	assign power_event_output   = pme_r;
	assign normal_rx_enable     = normal_rx_r;

endmodule

`default_nettype wire

// ### tb/wfd_wake_properties.sv
/*
 * Port-level assertions for the wake frame detector: status causes, clears,
 * routing and the normal reception level. Bound onto the top module.
 */
`timescale 1ns/1ps
`default_nettype none

module wfd_wake_properties (
	input wire logic                  ref_clk,               // Clock
	input wire logic                  reset_n,               // Reset, low
	input wire wfd_pkg::wfd_rx_byte_t rx,                    // Receive byte
	input wire logic [47:0]           station_address,       // Station
	input wire logic                  remote_wake_enable,    // Control
	input wire logic                  frame_wake_enable,     // Control
	input wire logic                  first_low_power_state, // Low power
	input wire logic                  wake_irq_enable,       // Routing
	input wire logic                  wake_pme_enable,       // Routing
	input wire logic [1:0]            status_clear,          // Clears
	input wire logic                  frame_wake_received,   // Status
	input wire logic                  remote_wake_received,  // Status
	input wire logic                  host_irq,              // Interrupt
	input wire logic                  power_event_output,    // Event
	input wire logic                  normal_rx_enable       // Reception
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);

	// End of frame, then status two edges on
	sequence s_eof_then_status;
		rx.valid && rx.eof ##2 $rose(frame_wake_received);
	endsequence

	a_irq_route: assert property (
		host_irq == ((frame_wake_received || remote_wake_received) && $past(wake_irq_enable)))
		else $error("host interrupt does not follow status");
	a_pme_route: assert property (
		power_event_output == ((frame_wake_received || remote_wake_received)
		&& $past(wake_pme_enable)))
		else $error("power event does not follow status");
	a_normal_rx_mode: assert property (
		normal_rx_enable == !$past(remote_wake_enable || frame_wake_enable
		|| first_low_power_state))
		else $error("normal reception level wrong");
	a_remote_last_byte: assert property (
		$rose(remote_wake_received) |->
		$past(rx.valid && rx.data == station_address[47:40]))
		else $error("remote status without final address byte");
	a_frame_at_eof: assert property (
		$rose(frame_wake_received) |-> $past(rx.valid && rx.eof, 2))
		else $error("frame status not two edges after frame end");
	a_remote_enabled: assert property (
		$rose(remote_wake_received) |-> $past(remote_wake_enable || first_low_power_state))
		else $error("remote status while detection off");
	a_frame_enabled: assert property (
		$rose(frame_wake_received) |-> $past(frame_wake_enable || first_low_power_state))
		else $error("frame status while detection off");
	a_frame_sticky: assert property (
		$fell(frame_wake_received) |-> $past(status_clear[0]))
		else $error("frame status dropped without clear");
	a_remote_sticky: assert property (
		$fell(remote_wake_received) |-> $past(status_clear[1]))
		else $error("remote status dropped without clear");

	c_frame_wake: cover property (s_eof_then_status);
endmodule

bind wake_frame_detector wfd_wake_properties u_props (
	.ref_clk(ref_clk), .reset_n(reset_n), .rx(rx), .station_address(station_address),
	.remote_wake_enable(remote_wake_enable), .frame_wake_enable(frame_wake_enable),
	.first_low_power_state(first_low_power_state), .wake_irq_enable(wake_irq_enable),
	.wake_pme_enable(wake_pme_enable), .status_clear(status_clear),
	.frame_wake_received(frame_wake_received), .remote_wake_received(remote_wake_received),
	.host_irq(host_irq), .power_event_output(power_event_output),
	.normal_rx_enable(normal_rx_enable));

`default_nettype wire

// ### tb/wfd_rx_source.sv
/*
 * Receive datapath model: plays one frame byte per clock into the detector.
 * Assumes the caller waits for send to return before the next frame.
 */
`timescale 1ns/1ps
`default_nettype none

module wfd_rx_source (
	input  wire logic                 ref_clk, // Receive clock
	output var wfd_pkg::wfd_rx_byte_t rx       // Byte stream
);
	initial rx = '0;

	task automatic send(input logic [7:0] q[$]);
		for (int i = 0; i < q.size(); i++)
		begin
			@(posedge ref_clk);
			rx <= '{1'b1, i == 0, i == q.size() - 1, q[i]};
		end
		@(posedge ref_clk);
		// Idle data is not the last byte, so no stale match
		rx <= '{1'b0, 1'b0, 1'b0, ~q[q.size() - 1]};
	endtask
endmodule

`default_nettype wire

// ### tb/wake_frame_detector_tb_top.sv
/*
 * Self-checking bench: pattern filter frames and remote-wake frames.
 * Assumes the detector, its package and the byte source model.
 */
`timescale 1ns/1ps
`default_nettype none

module wake_frame_detector_tb_top;
	localparam logic [47:0] STATION = 48'h5544_3322_1102;
	logic                     ref_clk;
	logic                     reset_n;
	wfd_pkg::wfd_rx_byte_t    rx;
	wfd_pkg::wfd_filter_cfg_t filter_cfg [wfd_pkg::NUM_FILTERS];
	wfd_pkg::wfd_filter_cfg_t cfg;
	logic                     remote_wake_enable, frame_wake_enable, first_low_power_state;
	logic                     wake_irq_enable, wake_pme_enable;
	logic [1:0]               status_clear;
	logic                     frame_wake_received, remote_wake_received;
	logic                     host_irq, power_event_output, normal_rx_enable;
	logic [7:0]               q[$];
	int                       n_fail;
	int                       num_checks;
	logic [3:0]  f_cmd [6] = '{4'h1, 4'h0, 4'h9, 4'h1, 4'h9, 4'h1};
	logic [15:0] f_bad [6] = '{16'h0000, 16'h0000, 16'h0000, 16'h0001, 16'h0000, 16'h0000};
	int          f_kind[6] = '{0, 0, 0, 0, 1, 3};
	logic        f_exp [6] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
	int          r_kind[7] = '{0, 0, 2, 1, 0, 0, 3};
	int          r_pre [7] = '{0, 15, 15, 0, 0, 0, 0};
	int          r_rep [7] = '{16, 0, 16, 16, 16, 16, 16};
	logic        r_en  [7] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
	logic        r_lp  [7] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
	logic        r_exp [7] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};

	wfd_rx_source src (.ref_clk(ref_clk), .rx(rx));

	wake_frame_detector dut (
		.ref_clk(ref_clk), .reset_n(reset_n), .rx(rx), .station_address(STATION),
		.filter_cfg(filter_cfg), .remote_wake_enable(remote_wake_enable),
		.frame_wake_enable(frame_wake_enable), .first_low_power_state(first_low_power_state),
		.wake_irq_enable(wake_irq_enable), .wake_pme_enable(wake_pme_enable),
		.status_clear(status_clear), .frame_wake_received(frame_wake_received),
		.remote_wake_received(remote_wake_received), .host_irq(host_irq),
		.power_event_output(power_event_output), .normal_rx_enable(normal_rx_enable));

	////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("FAIL %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask

	task automatic hdr(input int kind);
		q = {};
		for (int i = 0; i < 6; i++)
			if (kind == 2)
				q.push_back(8'hFF);
			else if (kind == 1)
				q.push_back(i == 0 ? 8'h01 : 8'h5E);
			else if (kind == 3)
				q.push_back(8'h06 + 8'(i));
			else
				q.push_back(STATION[8*i +: 8]);
		for (int i = 0; i < 6; i++)
			q.push_back(8'hA0 + 8'(i));
		q.push_back(8'h42);
	endtask

	task automatic sync_copies(input int n);
		repeat (6) q.push_back(wfd_pkg::SYNC_BYTE);
		repeat (n) for (int k = 0; k < 6; k++) q.push_back(STATION[8*k +: 8]);
	endtask

	function automatic logic [15:0] crc_of(input logic [7:0] off, input logic [31:0] m);
		logic [15:0] c;
		c = wfd_pkg::CRC_INIT;
		for (int j = 0; j < 31; j++)
			if (m[j])
				for (int b = 0; b < 8; b++)
					c = {c[14:0], 1'b0} ^ ((c[15] ^ q[off + j][b]) ? wfd_pkg::CRC_POLY : 16'h0000);
		return c;
	endfunction

	task automatic clear_status();
		@(posedge ref_clk);
		status_clear <= 2'b11;
		@(posedge ref_clk);
		status_clear <= 2'b00;
		cyc(1);
		check(frame_wake_received, 1'b0);
		check(remote_wake_received, 1'b0);
	endtask

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end

	initial
	begin
		repeat (20000) @(posedge ref_clk);
		n_fail++;
		wrap_up();
	end

	initial
	begin
		{reset_n, remote_wake_enable, frame_wake_enable, first_low_power_state} = '0;
		{wake_irq_enable, wake_pme_enable, status_clear} = '0;
		filter_cfg = '{default: '0};
		n_fail = 0;
		num_checks = 0;
		repeat (3) @(posedge ref_clk);
		reset_n <= 1'b1;
		cyc(1);
		check(normal_rx_enable, 1'b1);
		check(host_irq, 1'b0);
		@(posedge ref_clk);
		frame_wake_enable <= 1'b1;
		wake_irq_enable <= 1'b1;
		for (int f = 0; f < wfd_pkg::NUM_FILTERS; f++)
			for (int c = 0; c < 6; c++)
			begin
				hdr(f_kind[c]);
				for (int i = 0; i < 20; i++)
					q.push_back(8'h30 + 8'(i));
				cfg.mask = 32'h0000_0005 << f;
				cfg.command = f_cmd[c];
				cfg.offset = 8'(12 + f);
				cfg.crc = crc_of(cfg.offset, cfg.mask) ^ f_bad[c];
				@(posedge ref_clk);
				for (int g = 0; g < wfd_pkg::NUM_FILTERS; g++)
					filter_cfg[g] <= (g == f) ? cfg : '0;
				src.send(q);
				cyc(3);
				check(frame_wake_received, f_exp[c]);
				check(host_irq, f_exp[c]);
				check(power_event_output, 1'b0);
				clear_status();
			end
		$display("test pattern filters done");
		@(posedge ref_clk);
		frame_wake_enable <= 1'b0;
		wake_irq_enable <= 1'b0;
		wake_pme_enable <= 1'b1;
		for (int r = 0; r < 7; r++)
		begin
			@(posedge ref_clk);
			remote_wake_enable <= r_en[r];
			first_low_power_state <= r_lp[r];
			cyc(1);
			check(normal_rx_enable, !(r_en[r] || r_lp[r]));
			hdr(r_kind[r]);
			if (r_pre[r] > 0)
			begin
				sync_copies(r_pre[r]);
				q.push_back(8'h00);
			end
			sync_copies(r_rep[r]);
			repeat (4) q.push_back(8'hC0);
			src.send(q);
			cyc(2);
			check(remote_wake_received, r_exp[r]);
			check(power_event_output, r_exp[r]);
			check(host_irq, 1'b0);
			clear_status();
		end
		@(posedge ref_clk);
		remote_wake_enable <= 1'b0;
		first_low_power_state <= 1'b0;
		cyc(2);
		check(normal_rx_enable, 1'b1);
		$display("test remote wake done");
		wrap_up();
	end
endmodule

`default_nettype wire
